// File: hw/eeprom_pkg.sv
package eeprom_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // instruction layout, counted after the start bit
   localparam logic [4:0] HDR_BITS_X16 = 5'h0C;   // 2 opcode + 10 address
   localparam logic [4:0] HDR_BITS_X8  = 5'h0D;   // 2 opcode + 11 address
   localparam logic [4:0] WORD_BITS    = 5'h10;
   localparam logic [4:0] BYTE_BITS    = 5'h08;
   localparam int         WORD_ADDR_W  = 10;
   localparam int         BYTE_ADDR_W  = 11;

   // two-bit opcodes and the extension of the 00 group
   localparam logic [1:0] OP_EXT       = 2'h0;
   localparam logic [1:0] OP_WRITE     = 2'h1;
   localparam logic [1:0] OP_READ      = 2'h2;
   localparam logic [1:0] OP_ERASE     = 2'h3;
   localparam logic [1:0] EXT_DISABLE  = 2'h0;
   localparam logic [1:0] EXT_WR_ALL   = 2'h1;
   localparam logic [1:0] EXT_CLR_ALL  = 2'h2;
   localparam logic [1:0] EXT_ENABLE   = 2'h3;

   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////////////
   // timing: longest program time rounds down to whole cycles
   localparam int CLK_MHZ          = 125;
   localparam int PROG_TIME_US     = 5000;
   localparam int PROG_CYCLES_DEF  = PROG_TIME_US * CLK_MHZ;
   localparam int READ_FIFO_DEPTH  = 4;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HEAD = 3'b001,
      ST_DATA = 3'b010,
      ST_DONE = 3'b011,
      ST_READ = 3'b100
   } decode_e;

   typedef enum logic [1:0] {
      PG_WRITE     = 2'b00,
      PG_ERASE     = 2'b01,
      PG_WRITE_ALL = 2'b10,
      PG_CLEAR_ALL = 2'b11
   } prog_e;

   // one self-timed program request
   typedef struct packed {
      prog_e       op;
      logic        byteOrg;
      logic [10:0] addr;
      logic [15:0] data;
   } prog_req_s;

   // serial output pin: level and active-low enable
   typedef struct packed {
      logic level;
      logic drive_n;
   } pin_out_s;

endpackage

// File: hw/eeprom_read_fifo.sv
module eeprom_read_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : gCheck
      $error("fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW:0]      wrPtr;
   logic [PW:0]      rdPtr;
   wire              doPush = inValid & inReady;
   wire              doPop  = outValid & outReady;

   // extra pointer bit tells full from empty
   assign inReady  = (wrPtr ^ rdPtr) != {1'b1, {PW{1'b0}}};
   assign outValid = wrPtr != rdPtr;
   assign outData  = store[rdPtr[PW-1:0]];

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || flush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else
      begin
         if (doPush) wrPtr <= wrPtr + 1'b1;
         if (doPop)  rdPtr <= rdPtr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (doPush) store[wrPtr[PW-1:0]] <= inData;
   end

endmodule

// File: hw/serial_eeprom_port.sv
// Summary of operation
// - instruction is start bit, opcode, 10 or 11 address bits, then write data.
// - opcode 10 reads, 11 erases, 01 writes the addressed location.
// - opcode 00 plus two address bits: 11 enable, 00 disable, 10 clear, 01 fill.
// - headers are 13 bits in word mode and 14 in byte mode; seven instructions.
// - input bits are sampled on the rising serial clock edge.
// - output is released except during read data or program status.
// - after a program start, select shows low while busy, high when ready.
// - a one shifted in while status shows releases output at next falling edge.
// - write, erase, fill and clear need program_allow high; enable/disable do not.
// - read puts out one zero dummy bit, then the word msb first.
// - read output bits change on the rising serial clock edge.
// - continued clocking reads following words, wrapping from the top to 0.
// - only the first word of a sequential read has the dummy zero.
// - program cycle starts at the select falling edge, needs no more clocks.
// - single write clears the location itself; cycle lasts at most 5 ms.
// - erase leaves every bit of the location at one.
// - writing is disabled after reset until an enable instruction.
// - enable persists until disable; disable blocks all writes and clears.
// - reads work whether writing is enabled or not.
// - word_size_sel high selects 16-bit words, low selects 8-bit words.
// - clear-all sets every memory bit to one in one program cycle.
// - write-all stores its data in every location in one cycle.
module serial_eeprom_port
   import eeprom_pkg::*;
#(
   parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DEF,
   parameter int FIFO_DEPTH  = eeprom_pkg::READ_FIFO_DEPTH
) (
   input  wire logic     sys_clk,
   input  wire logic     rst_n,
   input  wire logic     chip_sel,
   input  wire logic     serial_clk,
   input  wire logic     serial_in,
   input  wire logic     word_size_sel,
   input  wire logic     program_allow,
   output eeprom_pkg::pin_out_s serialOut,
   output logic          busy,
   output logic          writeEnabled
);
   import eeprom_pkg::*;

   localparam int CW        = $clog2(PROG_CYCLES + 1);
   localparam int MEM_WORDS = 1 << WORD_ADDR_W;

   if (PROG_CYCLES < 8 || FIFO_DEPTH < 2) begin : gCheck
      $error("program cycle count below 8 or fifo too shallow");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage A is read only by stage B
   logic [4:0] syncA;
   logic [4:0] syncB;
   logic       sclkPrev;
   logic       csPrev;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         syncA    <= 5'h00;
         syncB    <= 5'h00;
         sclkPrev <= 1'b0;
         csPrev   <= 1'b0;
      end
      else
      begin
         syncA    <= {chip_sel, serial_clk, serial_in, word_size_sel, program_allow};
         syncB    <= syncA;
         sclkPrev <= syncB[3];
         csPrev   <= syncB[4];
      end
   end

   wire csHigh   = syncB[4];
   wire sinBit   = syncB[2];
   wire byteMode = !syncB[1];
   wire progOk   = syncB[0];
   wire skRise   = syncB[3] & !sclkPrev;
   wire skFall   = !syncB[3] & sclkPrev;
   wire csFall   = !csHigh & csPrev;

   ////////////////////////////////////////////////////////////////////////////////
   // decoder state and header fields
   decode_e     state;
   logic [4:0]  bitCnt;
   logic [12:0] hdr;
   logic [15:0] dataIn;
   logic [1:0]  opL;
   logic [1:0]  extL;
   logic [10:0] addrL;
   logic        instrByte;

   // organisation is frozen at the start bit
   wire [4:0]  hdrLen   = instrByte ? HDR_BITS_X8 : HDR_BITS_X16;
   wire [4:0]  dataLen  = instrByte ? BYTE_BITS : WORD_BITS;
   wire [12:0] hdrNext  = {hdr[11:0], sinBit};
   wire        hdrLast  = skRise & csHigh & (state == ST_HEAD) & (bitCnt == hdrLen - 5'h01);
   wire [1:0]  opF      = instrByte ? hdrNext[12:11] : hdrNext[11:10];
   wire [1:0]  extF     = instrByte ? hdrNext[10:9] : hdrNext[9:8];
   wire [10:0] addrF    = instrByte ? hdrNext[10:0] : {1'b0, hdrNext[9:0]};
   wire        opRead   = hdrLast & (opF == OP_READ);
   wire        extHit   = hdrLast & (opF == OP_EXT);
   wire        dataLast = skRise & csHigh & (state == ST_DATA) & (bitCnt == dataLen - 5'h01);

   // select low aborts whatever is partial; a complete one waits in done
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !csHigh)
      begin
         state  <= ST_IDLE;
         bitCnt <= 5'h00;
      end
      else if (skRise)
      begin
         case (state)
            ST_IDLE:
            begin
               if (sinBit && !busy) state <= ST_HEAD;
               bitCnt <= 5'h00;
            end
            ST_HEAD:
            begin
               bitCnt <= hdrLast ? 5'h00 : bitCnt + 5'h01;
               if (hdrLast)
               begin
                  case (opF)
                     OP_READ:  state <= ST_READ;
                     OP_WRITE: state <= ST_DATA;
                     OP_ERASE: state <= ST_DONE;
                     default:
                     begin
                        if (extF == EXT_WR_ALL)      state <= ST_DATA;
                        else if (extF == EXT_CLR_ALL) state <= ST_DONE;
                        else                          state <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_DATA:
            begin
               bitCnt <= bitCnt + 5'h01;
               if (dataLast) state <= ST_DONE;
            end
            ST_DONE: state <= ST_DONE;
            ST_READ: state <= ST_READ;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // field capture
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         hdr       <= 13'h0000;
         dataIn    <= 16'h0000;
         opL       <= OP_READ;
         extL      <= EXT_DISABLE;
         addrL     <= 11'h000;
         instrByte <= 1'b0;
      end
      else if (skRise && csHigh)
      begin
         if (state == ST_IDLE) instrByte <= byteMode;
         if (state == ST_HEAD) hdr <= hdrNext;
         if (state == ST_DATA) dataIn <= {dataIn[14:0], sinBit};
         if (hdrLast)
         begin
            opL   <= opF;
            extL  <= extF;
            addrL <= addrF;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write-enable latch; reset stands for power-up
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         writeEnabled <= 1'b0;
      else if (extHit && extF == EXT_ENABLE)
         writeEnabled <= 1'b1;
      else if (extHit && extF == EXT_DISABLE)
         writeEnabled <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // self-timed program engine
   prog_req_s       progReq;
   logic [CW-1:0]   progCnt;
   wire prog_e      launchOp = (opL == OP_WRITE) ? PG_WRITE :
                               (opL == OP_ERASE) ? PG_ERASE :
                               (extL == EXT_WR_ALL) ? PG_WRITE_ALL : PG_CLEAR_ALL;
   // both gates checked at the select edge, so enable/disable never need them
   wire launch    = csFall & (state == ST_DONE) & writeEnabled & progOk & !busy;
   wire memStrobe = busy & (progCnt == '0);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         busy    <= 1'b0;
         progCnt <= '0;
      end
      else if (launch)
      begin
         busy    <= 1'b1;
         progCnt <= CW'(PROG_CYCLES - 1);
      end
      else if (busy)
      begin
         busy    <= progCnt != '0;
         progCnt <= progCnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         progReq <= '0;
      else if (launch)
         progReq <= '{op: launchOp, byteOrg: instrByte, addr: addrL, data: dataIn};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // array: auto-clear is implicit, the whole addressed word or byte is replaced
   logic [15:0] mem [MEM_WORDS];
   wire allOp   = progReq.op[1];
   wire eraseOp = progReq.op == PG_ERASE || progReq.op == PG_CLEAR_ALL;
   wire [WORD_ADDR_W-1:0] wordIdx = progReq.byteOrg ? progReq.addr[10:1] : progReq.addr[9:0];
   wire [15:0] wrWord = eraseOp ? ERASED_WORD :
                        progReq.byteOrg ? {progReq.data[7:0], progReq.data[7:0]} : progReq.data;
   wire hiEn    = !progReq.byteOrg | allOp | progReq.addr[0];
   wire loEn    = !progReq.byteOrg | allOp | !progReq.addr[0];

   for (genvar g = 0; g < MEM_WORDS; g++) begin : gMem
      wire hit = memStrobe & (allOp | (wordIdx == WORD_ADDR_W'(g)));
      always_ff @(posedge sys_clk)
      begin
         if (hit && hiEn) mem[g][15:8] <= wrWord[15:8];
         if (hit && loEn) mem[g][7:0]  <= wrWord[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read prefetch into the fifo; a stalled shifter holds the fetcher back
   logic        fetchOn;
   logic        fetchByte;
   logic [10:0] fetchAddr;
   logic        fifoInReady;
   logic        fifoOutValid;
   logic [15:0] fifoOut;
   wire [15:0] fetchWord = mem[fetchByte ? fetchAddr[10:1] : fetchAddr[9:0]];
   wire [15:0] fetchData = !fetchByte ? fetchWord :
                           {8'h00, fetchAddr[0] ? fetchWord[15:8] : fetchWord[7:0]};
   wire        push      = fetchOn & fifoInReady;
   // word mode wraps at 10 bits, byte mode at 11
   wire [10:0] fetchNext = fetchByte ? fetchAddr + 11'h001 :
                           {1'b0, fetchAddr[9:0] + 10'h001};

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !csHigh)
      begin
         fetchOn   <= 1'b0;
         fetchByte <= 1'b0;
         fetchAddr <= 11'h000;
      end
      else if (opRead)
      begin
         fetchOn   <= 1'b1;
         fetchByte <= instrByte;
         fetchAddr <= addrF;
      end
      else if (push)
         fetchAddr <= fetchNext;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output shifter: dummy zero once, then words back to back
   logic        readDrive;
   logic        outBit;
   logic [15:0] outWord;
   logic [4:0]  bitsLeft;
   wire pop = skRise & csHigh & (state == ST_READ) & (bitsLeft == 5'h00) & fifoOutValid;
   wire [15:0] popAligned = fetchByte ? {fifoOut[7:0], 8'h00} : fifoOut;
   wire        popMsb     = popAligned[15];

   eeprom_read_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) uFifo (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .flush    (!csHigh || opRead),
      .inValid  (push),
      .inReady  (fifoInReady),
      .inData   (fetchData),
      .outValid (fifoOutValid),
      .outReady (pop),
      .outData  (fifoOut)
   );

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !csHigh)
      begin
         readDrive <= 1'b0;
         outBit    <= 1'b0;
         outWord   <= 16'h0000;
         bitsLeft  <= 5'h00;
      end
      else if (opRead)
      begin
         readDrive <= 1'b1;
         outBit    <= 1'b0;
         bitsLeft  <= 5'h00;
      end
      else if (pop)
      begin
         outBit   <= popMsb;
         outWord  <= {popAligned[14:0], 1'b0};
         bitsLeft <= (fetchByte ? BYTE_BITS : WORD_BITS) - 5'h01;
      end
      else if (skRise && state == ST_READ && bitsLeft != 5'h00)
      begin
         outBit   <= outWord[15];
         outWord  <= {outWord[14:0], 1'b0};
         bitsLeft <= bitsLeft - 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ready/busy status, released by a one and the following falling edge
   logic statusArmed;
   logic releasePend;
   wire  statusShow = statusArmed & csHigh;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         statusArmed <= 1'b0;
         releasePend <= 1'b0;
      end
      else if (launch)
      begin
         statusArmed <= 1'b1;
         releasePend <= 1'b0;
      end
      else if (releasePend && skFall)
      begin
         statusArmed <= 1'b0;
         releasePend <= 1'b0;
      end
      else if (statusShow && skRise && sinBit)
         releasePend <= 1'b1;
   end

   // pin flop; status gives low while busy, high once ready
   wire next_drive = readDrive | statusShow;
   wire next_level = readDrive ? outBit : !busy;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         serialOut <= '{level: 1'b0, drive_n: 1'b1};
      else
         serialOut <= '{level: next_level, drive_n: !next_drive};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_leading_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_IDLE && csHigh && skRise && !sinBit) |=> state == ST_IDLE)
      else $error("leading zero taken as start bit");
   a_read_dummy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      opRead |-> ##2 (!serialOut.drive_n && !serialOut.level))
      else $error("read did not start with a driven zero");
   a_output_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!readDrive && !statusShow) |=> serialOut.drive_n)
      else $error("output driven outside read or status");
   a_status_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (statusShow && !readDrive) |=> (!serialOut.drive_n && serialOut.level == !$past(busy)))
      else $error("status level does not follow busy");
   a_status_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (releasePend && skFall && !launch) |=> !statusArmed ##1 serialOut.drive_n)
      else $error("status not released at falling edge");
   a_launch_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(busy) |-> ($past(writeEnabled) && $past(progOk) && $past(csFall)))
      else $error("program cycle without enable, allow or select edge");
   a_cycle_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(busy) |-> busy [*8])
      else $error("program cycle ended too early");
   a_abort_clean: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (csFall && state != ST_DONE) |=> !$rose(busy))
      else $error("partial instruction started a program cycle");
   a_disable_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (extHit && extF == EXT_DISABLE) |=> !writeEnabled)
      else $error("disable instruction left writing enabled");
   a_read_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pop && csHigh) ##1 csHigh |-> ##1 serialOut.level == $past(popMsb, 2))
      else $error("popped word msb not on the pin");
   a_erase_ones: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (memStrobe && eraseOp && !progReq.byteOrg) |=> mem[wordIdx] == ERASED_WORD)
      else $error("erased word not all ones");

   c_read_start:  cover property (@(posedge sys_clk) disable iff (!rst_n) opRead);
   c_second_word: cover property (@(posedge sys_clk) disable iff (!rst_n) pop ##[1:400] pop);
   c_program:     cover property (@(posedge sys_clk) disable iff (!rst_n) launch);
   c_release:     cover property (@(posedge sys_clk) disable iff (!rst_n) releasePend && skFall);

endmodule

// File: sim/eeprom_host_model.sv
module eeprom_host_model
   import eeprom_pkg::*;
(
   input  wire logic                 sys_clk,
   output logic                      chip_sel,
   output logic                      serial_clk,
   output logic                      serial_in,
   input  wire eeprom_pkg::pin_out_s serialOut
);
   timeunit 1ns;
   timeprecision 100ps;

   // a released line reads the opposite of its last level, so a missing drive shows
   wire lineLevel = serialOut.drive_n ? !serialOut.level : serialOut.level;

   // idle pins: clock parked low, data line not left at a stale level
   initial
   begin
      chip_sel   = 1'b0;
      serial_clk = 1'b0;
      serial_in  = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // half of the 80 ns link period
   task automatic halfBit();
      repeat (5) @(posedge sys_clk);
   endtask

   // shift n bits msb first; rx holds the pin level seen after each rising edge
   task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      chip_sel <= 1'b1;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in <= tx[i];   // set while clock low, steady at the rise
         halfBit();
         if (i < n - 1)
            rx = {rx[62:0], lineLevel};
         serial_clk <= 1'b1;
         halfBit();
         serial_clk <= 1'b0;
      end
      halfBit();
      rx = {rx[62:0], lineLevel};   // late sample, long after the pin settled
   endtask

   // raise select alone to poll status; separate data wire, so no clash
   task automatic select();
      chip_sel <= 1'b1;
      repeat (10) @(posedge sys_clk);
   endtask

   // drop select and keep it low well beyond the minimum low time
   task automatic deselect();
      halfBit();
      chip_sel  <= 1'b0;
      serial_in <= ~serial_in;
      repeat (40) @(posedge sys_clk);   // 320 ns low
   endtask
endmodule

// File: sim/serial_eeprom_port_test.sv
`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
   $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module serial_eeprom_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   import eeprom_pkg::*;

   typedef struct packed {
      logic [1:0]  op;
      logic [9:0]  addr;
      logic [15:0] data;
      logic        allow;
      logic [9:0]  readAddr;
      logic [15:0] expWord;
   } row_s;

   // command, then readback of one word
   localparam row_s ROWS [8] = '{
      '{OP_EXT,   10'h200, 16'h0000, 1'b1, 10'h123, 16'hFFFF},
      '{OP_WRITE, 10'h123, 16'hA5C3, 1'b1, 10'h123, 16'hA5C3},
      '{OP_WRITE, 10'h123, 16'h0F0F, 1'b0, 10'h123, 16'hA5C3},
      '{OP_ERASE, 10'h123, 16'h0000, 1'b1, 10'h123, 16'hFFFF},
      '{OP_EXT,   10'h100, 16'h1234, 1'b1, 10'h3FF, 16'h1234},
      '{OP_WRITE, 10'h3FF, 16'hBEEF, 1'b1, 10'h3FF, 16'hBEEF},
      '{OP_EXT,   10'h000, 16'h0000, 1'b1, 10'h3FF, 16'hBEEF},
      '{OP_WRITE, 10'h3FF, 16'h0000, 1'b1, 10'h3FF, 16'hBEEF}
   };

   logic        sys_clk;
   logic        rst_n;
   logic        word_size_sel;
   logic        program_allow;
   logic        chip_sel;
   logic        serial_clk;
   logic        serial_in;
   logic        busy;
   logic        writeEnabled;
   pin_out_s    serialOut;
   logic [63:0] rx;
   int          fails = 0;
   int          checked = 0;

   // short program cycle keeps the run brief
   serial_eeprom_port #(.PROG_CYCLES(100), .FIFO_DEPTH(4)) uut (.sys_clk(sys_clk),
      .rst_n(rst_n), .chip_sel(chip_sel), .serial_clk(serial_clk), .serial_in(serial_in),
      .word_size_sel(word_size_sel), .program_allow(program_allow), .serialOut(serialOut),
      .busy(busy), .writeEnabled(writeEnabled));

   eeprom_host_model host (.sys_clk(sys_clk), .chip_sel(chip_sel), .serial_clk(serial_clk),
      .serial_in(serial_in), .serialOut(serialOut));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // bounded wait for the program cycle to end
   task automatic waitIdle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 1000)
      begin
         fails++;
         $display("[FAIL] busy expected 0 seen 1");
         summarize();
      end
   endtask

   // write-type commands carry data; others are header only
   task automatic send(input row_s r);
      program_allow <= r.allow;
      if (r.op == OP_WRITE || (r.op == OP_EXT && r.addr[9:8] == EXT_WR_ALL))
         host.xfer({35'h0, 1'b1, r.op, r.addr, r.data}, 29, rx);
      else
         host.xfer({51'h0, 1'b1, r.op, r.addr}, 13, rx);
      host.deselect();
      waitIdle();
   endtask

   // read of n edges after lead zeros; dummy zero sits right after the header
   task automatic readAt(input logic [9:0] a, input int n, input int lead = 0);
      host.xfer({51'h0, 1'b1, OP_READ, a} << (n - 13 - lead), n, rx);
      `CHECK("dummy bit", 1'b0, rx[n-13-lead]);
      `CHECK("drive_n in read", 1'b0, serialOut.drive_n);
      host.deselect();
      `CHECK("drive_n after read", 1'b1, serialOut.drive_n);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      word_size_sel = 1'b1;
      program_allow = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHECK("drive_n at reset", 1'b1, serialOut.drive_n);
      `CHECK("enable at reset", 1'b0, writeEnabled);
      host.xfer({35'h0, 1'b1, OP_WRITE, 10'h123, 16'h5555}, 29, rx);
      host.deselect();
      `CHECK("busy when locked", 1'b0, busy);
      send('{OP_EXT, 10'h300, 16'h0, 1'b1, 10'h0, 16'h0});
      `CHECK("enable latch", 1'b1, writeEnabled);
      $display("reset and enable done");
      // ordinary commands, each followed by a readback
      foreach (ROWS[i])
      begin
         send(ROWS[i]);
         readAt(ROWS[i].readAddr, 29);
         `CHECK("readback", ROWS[i].expWord, rx[15:0]);
         $display("row %0d done", i);
      end
      // sequential read across the top of the array
      readAt(10'h3FF, 45);
      `CHECK("top word", 16'hBEEF, rx[31:16]);
      `CHECK("wrapped word", 16'h1234, rx[15:0]);
      $display("sequential read done");
      // status polling and release by a one on the input
      send('{OP_EXT, 10'h300, 16'h0, 1'b1, 10'h0, 16'h0});
      host.xfer({35'h0, 1'b1, OP_WRITE, 10'h010, 16'hC3C3}, 29, rx);
      host.deselect();
      host.select();
      `CHECK("status busy", 2'b00, serialOut);
      waitIdle();
      repeat (10) @(posedge sys_clk);
      `CHECK("status ready", 2'b10, serialOut);
      host.xfer(64'h1, 1, rx);
      repeat (5) @(posedge sys_clk);
      `CHECK("status release", 1'b1, serialOut.drive_n);
      host.deselect();
      readAt(10'h010, 31, 2);
      `CHECK("after abort", 16'hC3C3, rx[15:0]);
      $display("status test done");
      // power cycle mid-run: latch cleared, memory kept
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHECK("enable after reset", 1'b0, writeEnabled);
      send('{OP_EXT, 10'h300, 16'h0, 1'b1, 10'h0, 16'h0});
      $display("mid-run reset done");
      // byte organisation: low byte written, then both bytes of the top word read
      word_size_sel <= 1'b0;
      host.xfer({42'h0, 1'b1, OP_WRITE, 11'h7FE, 8'h5A}, 22, rx);
      host.deselect();
      waitIdle();
      host.xfer({50'h0, 1'b1, OP_READ, 11'h7FE} << 16, 30, rx);
      `CHECK("byte dummy", 1'b0, rx[16]);
      `CHECK("byte write", 8'h5A, rx[15:8]);
      `CHECK("byte read", 8'hBE, rx[7:0]);
      host.deselect();
      $display("byte read done");
      summarize();
   end
endmodule
